// ### bench/pst_drive_model.sv
// Behavioural drive on the far side of the link layer.
`timescale 1ns/1ps
module pst_drive_model (
	output logic rx_valid,
	output logic rx_sof,
	output logic rx_eof,
	output logic [31:0] rx_data,
	output logic tx_ready,
	input wire logic pclk
);
	// Largest burst of 16 sectors still fits one data frame
	localparam int MAX_BYTES = 16 * 512;
	initial begin
		{rx_valid, rx_sof, rx_eof, tx_ready} = 4'h0;
		rx_data = 32'h00000000;
	end
	// Random stalls keep outgoing dwords waiting
	always @(posedge pclk)
		tx_ready <= $urandom_range(3, 0) != 0;
	// Sends one frame, CRC dword last with the end mark
	task automatic send(input logic [31:0] f [$]);
		f.push_back(32'($urandom));
		foreach (f[i]) begin
			@(posedge pclk);
			rx_valid <= 1'b1;
			rx_sof <= i == 0;
			rx_eof <= i == f.size() - 1;
			rx_data <= f[i];
		end
		@(posedge pclk);
		{rx_valid, rx_sof, rx_eof} <= 3'h0;
		rx_data <= ~f[f.size() - 1]; // Idle line must not look like a held dword
	endtask
	// Setup frame; count kept even, bit 13 gives direction
	task automatic setup(input logic dir, input logic [7:0] st, er, es, input logic [15:0] cnt);
		logic [15:0] c;
		c = (cnt > 16'(MAX_BYTES)) ? 16'(MAX_BYTES) : cnt & 16'hFFFE;
		if (c == 16'h0000)
			c = 16'h0002;
		send('{{er, st, 2'b00, dir, 13'h005F}, 32'($urandom), 32'h00000000,
			{es, 24'h000000}, {16'h0000, c}});
	endtask
	// Data frame: header dword then the payload
	task automatic data(input logic [31:0] p [$]);
		p.push_front(32'h00000046);
		send(p);
	endtask
endmodule

// ### bench/pst_pio_transport_tb.sv
// Self-checking bench of the PIO data transport.
`timescale 1ns/1ps
module pst_pio_transport_tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rx_data, tx_data;
	logic rx_valid, rx_sof, rx_eof, tx_valid, tx_sof, tx_eof, tx_ready;
	int error_cnt = 0;
	int samples_checked = 0;
	int cycles = 0;
	logic [32:0] tx_q [$]; // Expected outgoing dwords: end mark, data
	logic [64:0] rd_q [$]; // Expected reads: error flag, mask, data
	logic [64:0] e; // Oldest read note
	// ========
	// Design, drive and checker
	pst_pio_transport u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid),
		.rx_sof(rx_sof), .rx_eof(rx_eof), .rx_data(rx_data), .tx_valid(tx_valid), .tx_sof(tx_sof), .tx_eof(tx_eof),
		.tx_data(tx_data), .tx_ready(tx_ready), .irq(irq));
	pst_drive_model u_drv (.rx_valid(rx_valid), .rx_sof(rx_sof), .rx_eof(rx_eof), .rx_data(rx_data),
		.tx_ready(tx_ready), .pclk(pclk));
	initial pclk = 1'b0;
	always #12.5 pclk = ~pclk;
	// ========
	// Checking
	task automatic chk(input logic [32:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic results;
		$display("Checks %0d, errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Compares each result with the oldest note
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite) begin
			e = rd_q.pop_front();
			chk({pslverr, prdata & e[63:32]}, {e[64], e[31:0]});
		end
		if (tx_valid && tx_ready)
			chk({tx_eof, tx_data}, tx_q.pop_front());
	end
	// Cuts a hang short
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			results();
		end
	end
	// ========
	// Bus master; waits for ready with no assumed latency
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (!pready);
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a; // Released bus shows no stale address or data
		pwdata <= ~d;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] m, d, input logic s);
		rd_q.push_back({s, m, d & m});
		apb(1'b0, a, 32'h00000000);
	endtask
	// ========
	// Scenarios
	initial begin
		logic [7:0] st, er, es;
		logic [15:0] old;
		logic [15:0] w [4];
		void'($urandom(32'hBF3297E0));
		{psel, penable, pwrite, paddr, pwdata} = '0;
		presetn = 1'b0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		rd(12'h004, 32'h0000FFFF, 32'h00000080, 1'b0); // Status after reset
		rd(12'h01C, 32'hFFFFFFFF, 32'h00000000, 1'b1); // Unmapped place is refused
		apb(1'b1, 12'h018, 32'h00000005);
		for (int k = 0; k < 2; k++) begin
			{st, er, es} = 24'($urandom);
			foreach (w[i])
				w[i] = 16'($urandom);
			// Outbound: three words, so the tail is padded
			tx_q.push_back(33'h000000046);
			tx_q.push_back({1'b0, w[1], w[0]});
			tx_q.push_back({1'b1, 16'h0000, w[2]});
			u_drv.setup(1'b0, st, er, es, 16'h0006);
			rd(12'h004, 32'h0000FFFF, {16'h0000, er, st}, 1'b0);
			rd(12'h008, 32'h0000FFFF, 32'h00000006, 1'b0);
			apb(1'b1, 12'h000, {16'h0000, w[0]});
			apb(1'b1, 12'h000, {16'h0000, w[1]});
			rd(12'h004, 32'h0000FFFF, {16'h0000, er, st}, 1'b0);
			apb(1'b1, 12'h000, {16'h0000, w[2]});
			rd(12'h004, 32'h0000FFFF, {16'h0000, er, es}, 1'b0);
			// Interrupt raised, masked and cleared
			chk({32'h00000000, irq}, 33'h000000001);
			apb(1'b1, 12'h018, 32'h00000000);
			repeat (2) @(posedge pclk);
			chk({32'h00000000, irq}, 33'h000000000);
			rd(12'h010, 32'h00000007, 32'h00000005, 1'b0);
			apb(1'b1, 12'h014, 32'h0000001F);
			rd(12'h010, 32'h0000001F, 32'h00000000, 1'b0);
			apb(1'b1, 12'h018, 32'h00000005);
			// Inbound: four words, shadows wait for the data frame
			old = {er, es};
			{st, er, es} = 24'($urandom);
			u_drv.setup(1'b1, st, er, es, 16'h0008);
			rd(12'h004, 32'h0000FFFF, {16'h0000, old}, 1'b0);
			u_drv.data('{{w[1], w[0]}, {w[3], w[2]}});
			rd(12'h004, 32'h0000FFFF, {16'h0000, er, st}, 1'b0);
			foreach (w[i])
				rd(12'h000, 32'h0000FFFF, {16'h0000, w[i]}, 1'b0);
			rd(12'h004, 32'h0000FFFF, {16'h0000, er, es}, 1'b0);
			rd(12'h000, 32'h0000FFFF, 32'h00000000, 1'b0);
			apb(1'b1, 12'h014, 32'h0000001F);
		end
		// Unknown frame type is skipped and flagged
		u_drv.send('{32'h00000027, 32'h00000000});
		rd(12'h010, 32'h00000008, 32'h00000008, 1'b0);
		// Data with no setup waiting belongs to the other path; a disabled transport skips setups
		u_drv.data('{32'h00000001});
		apb(1'b1, 12'h00C, 32'h00000000);
		rd(12'h00C, 32'h00000001, 32'h00000000, 1'b0);
		u_drv.setup(1'b0, st, er, es, 16'h0004);
		rd(12'h010, 32'h00000017, 32'h00000000, 1'b0);
		// Reset in mid-run brings back the reset values
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(12'h00C, 32'h00000001, 32'h00000001, 1'b0);
		rd(12'h004, 32'h0000FFFF, 32'h00000080, 1'b0);
		rd(12'h010, 32'hFFFFFFFF, 32'h00000000, 1'b0);
		repeat (20) @(posedge pclk);
		chk(33'(tx_q.size() + rd_q.size()), 33'h000000000);
		results();
	end
endmodule
bind pst_pio_transport pst_props u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .rx_valid(rx_valid), .rx_sof(rx_sof),
	.rx_eof(rx_eof), .rx_data(rx_data), .tx_valid(tx_valid), .tx_sof(tx_sof), .tx_eof(tx_eof),
	.tx_data(tx_data), .tx_ready(tx_ready), .irq(irq));

// ### bench/pst_props.sv
// Port checker of the PIO data transport.
`timescale 1ns/1ps
module pst_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic rx_valid,
	input wire logic rx_sof,
	input wire logic rx_eof,
	input wire logic [31:0] rx_data,
	input wire logic tx_valid,
	input wire logic tx_sof,
	input wire logic tx_eof,
	input wire logic [31:0] tx_data,
	input wire logic tx_ready,
	input wire logic irq
);
	// ========
	// Helpers
	logic out_reg, out_next; // Outbound setup inside the current rx frame
	logic [11:0] len_reg, len_next; // Payload dwords taken in the current tx frame
	logic en_reg, en_next; // Transport enable as last written; disabled setups send no header
	// Next values of the helpers
	always_comb begin
		out_next = out_reg;
		len_next = len_reg;
		en_next = en_reg;
		if (psel && penable && pready && pwrite && paddr == 12'h00C)
			en_next = pwdata[0];
		if (rx_valid && rx_sof)
			out_next = rx_data[7:0] == 8'h5F && !rx_data[13] && en_reg;
		else if (rx_valid && rx_eof)
			out_next = 1'b0;
		if (tx_valid && tx_ready)
			len_next = tx_sof ? 12'h000 : len_reg + 12'h001;
	end
	// Helper registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_reg <= 1'b0;
			len_reg <= 12'h000;
			en_reg <= 1'b1;
		end else begin
			out_reg <= out_next;
			len_reg <= len_next;
			en_reg <= en_next;
		end
	end
	// ========
	// Properties
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_HDR: assert property (tx_valid && tx_sof |-> tx_data == 32'h00000046)
		else $error("header dword wrong");
	AST_MIN: assert property (tx_valid && tx_sof |-> !tx_eof)
		else $error("frame without payload");
	AST_MAX: assert property (tx_valid && tx_ready && !tx_sof |-> len_reg < 12'h800)
		else $error("payload above limit");
	AST_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_eof))
		else $error("dword dropped before taken");
	AST_CLOSE: assert property (tx_valid && tx_ready && tx_eof |=> !tx_valid)
		else $error("frame not closed");
	AST_OUT_HDR: assert property (rx_valid && rx_eof && out_reg |=> tx_valid && tx_sof)
		else $error("no header after outbound setup");
	AST_ACCESS: assert property (pready |-> psel && penable)
		else $error("ready outside access");
	AST_MASK: assert property (psel && penable && pready && pwrite && paddr == 12'h018 && pwdata[4:0] == 5'h00
		|-> ##[1:2] !irq) else $error("masked irq stays high");
endmodule

// ### design/pst_dword_mem.sv
// Payload store for one received data frame, registered read port.
`timescale 1ns/1ps
module pst_dword_mem #(
	parameter int DEPTH = 2048,
	parameter int AW = 11
) (
	input wire logic pclk,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [31:0] wr_data,
	input wire logic [AW-1:0] rd_addr,
	output logic [31:0] rd_data
);
	// ==========================================================
	// Storage; no reset so it maps onto block RAM
	logic [31:0] mem [0:DEPTH-1];

	// Write port and registered read
	always_ff @(posedge pclk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule

// ### design/pst_pio_transport.sv
// Host adapter PIO setup and data frame transport with APB shadow registers.
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "pst_params.svh"

module pst_pio_transport
	import pst_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rx_valid,
	input wire logic rx_sof,
	input wire logic rx_eof,
	input wire logic [31:0] rx_data,
	output logic tx_valid,
	output logic tx_sof,
	output logic tx_eof,
	output logic [31:0] tx_data,
	input wire logic tx_ready,
	output logic irq
);
	// ==========================================================
	// State
	pst_rx_state_t rx_state_reg, rx_state_next; // Receive framer
	logic [2:0] idx_reg, idx_next; // Dword index inside a setup frame
	logic [31:0] dw0_reg, dw0_next; // Setup dword 0 (type, dir, status, error)
	logic [7:0] hold_estat_reg, hold_estat_next; // Held ending status
	logic [15:0] hold_cnt_reg, hold_cnt_next; // Captured transfer count
	logic [7:0] sh_status_reg, sh_status_next; // Shadow status
	logic [7:0] sh_error_reg, sh_error_next; // Shadow error
	logic [7:0] hold_status_reg, hold_status_next; // Held start status (inbound)
	logic [7:0] hold_error_reg, hold_error_next; // Held error (inbound)
	logic [15:0] count_reg, count_next; // Countdown in bytes
	logic out_act_reg, out_act_next; // Outbound PIO transfer open
	logic in_wait_reg, in_wait_next; // Inbound setup seen, data awaited
	logic in_act_reg, in_act_next; // Inbound data ready for reads
	logic half_reg, half_next; // Which word of the current dword
	logic [15:0] low_reg, low_next; // Parked low word of outbound dword
	logic [11:0] wr_ptr_reg, wr_ptr_next; // Payload dwords stored
	logic [11:0] rd_ptr_reg, rd_ptr_next; // Payload dword being read
	logic pend_v_reg, pend_v_next; // A dword waits until it is known not CRC
	logic [31:0] pend_reg, pend_next;
	logic en_reg, en_next; // Transport enable
	logic [`PST_EV_W-1:0] ist_reg, ist_next; // Sticky events
	logic [`PST_EV_W-1:0] ien_reg, ien_next; // Event enables
	logic irq_reg, irq_next;
	logic tx_valid_reg, tx_valid_next;
	logic tx_sof_reg, tx_sof_next;
	logic tx_eof_reg, tx_eof_next;
	logic [31:0] tx_data_reg, tx_data_next;
	logic pready_reg, pready_next;
	logic pslverr_reg, pslverr_next;
	logic [31:0] prdata_reg, prdata_next;
	// Memory port
	logic mem_we;
	logic [10:0] mem_waddr;
	logic [31:0] mem_wdata;
	logic [31:0] mem_q;
	// Helpers
	logic acc_wait, acc_done, hit, tx_busy;
	logic [`PST_EV_W-1:0] ev;
	logic [15:0] dec_cnt;

	pst_dword_mem #(.DEPTH(2048), .AW(11)) u_mem (
		.pclk(pclk),
		.wr_en(mem_we),
		.wr_addr(mem_waddr),
		.wr_data(mem_wdata),
		.rd_addr(rd_ptr_reg[10:0]),
		.rd_data(mem_q)
	);

	// ==========================================================
	// Next-state logic
	always_comb begin
		rx_state_next = rx_state_reg;
		idx_next = idx_reg;
		dw0_next = dw0_reg;
		hold_estat_next = hold_estat_reg;
		hold_cnt_next = hold_cnt_reg;
		sh_status_next = sh_status_reg;
		sh_error_next = sh_error_reg;
		hold_status_next = hold_status_reg;
		hold_error_next = hold_error_reg;
		count_next = count_reg;
		out_act_next = out_act_reg;
		in_wait_next = in_wait_reg;
		in_act_next = in_act_reg;
		half_next = half_reg;
		low_next = low_reg;
		wr_ptr_next = wr_ptr_reg;
		rd_ptr_next = rd_ptr_reg;
		pend_v_next = pend_v_reg;
		pend_next = pend_reg;
		en_next = en_reg;
		ien_next = ien_reg;
		tx_valid_next = tx_valid_reg;
		tx_sof_next = tx_sof_reg;
		tx_eof_next = tx_eof_reg;
		tx_data_next = tx_data_reg;
		pready_next = 1'b0;
		pslverr_next = 1'b0;
		prdata_next = prdata_reg;
		mem_we = 1'b0;
		mem_waddr = 11'h000;
		mem_wdata = 32'h0000_0000;
		ev = '0;
		dec_cnt = count_reg - 16'h0002;
		acc_wait = psel & penable & ~pready_reg;
		acc_done = psel & penable & pready_reg;
		// Unmapped and reserved offsets answer with an error
		hit = (paddr[11:5] == 7'h00) & (paddr[4:0] <= 5'h18) & (paddr[1:0] == 2'b00);
		tx_busy = tx_valid_reg & ~tx_ready;

		// Link takes the outgoing dword
		if (tx_valid_reg && tx_ready) begin
			tx_valid_next = 1'b0;
		end

		// Receive framing; frames are ignored while disabled
		if (rx_valid) begin
			case (rx_state_reg)
				PST_RX_IDLE: begin
					if (rx_sof && !rx_eof) begin
						idx_next = 3'h1;
						if (!en_reg) begin
							rx_state_next = PST_RX_SKIP;
						end else if (rx_data[7:0] == `PST_TYPE_SETUP) begin
							dw0_next = rx_data;
							rx_state_next = PST_RX_SETUP;
						end else if (rx_data[7:0] == `PST_TYPE_DATA && in_wait_reg) begin
							// Start values go live as the data frame arrives
							sh_status_next = hold_status_reg;
							sh_error_next = hold_error_reg;
							in_wait_next = 1'b0;
							wr_ptr_next = 12'h000;
							pend_v_next = 1'b0;
							rx_state_next = PST_RX_DATA;
						end else if (rx_data[7:0] == `PST_TYPE_DATA) begin
							// Data outside a PIO phase belongs to the DMA path
							rx_state_next = PST_RX_SKIP;
						end else begin
							ev[`PST_EV_BADTYPE] = 1'b1;
							rx_state_next = PST_RX_SKIP;
						end
					end
				end
				PST_RX_SETUP: begin
					idx_next = idx_reg + 3'h1;
					if (idx_reg == 3'h3) begin
						hold_estat_next = rx_data[31:24];
					end
					if (idx_reg == 3'h4) begin
						hold_cnt_next = rx_data[15:0];
					end
					// The end-of-frame dword is the CRC
					if (rx_eof) begin
						rx_state_next = PST_RX_IDLE;
						ev[`PST_EV_SETUP] = 1'b1;
						count_next = hold_cnt_reg;
						half_next = 1'b0;
						if (!dw0_reg[`PST_DIR_BIT]) begin
							// Outbound: start values take effect at once
							sh_status_next = dw0_reg[23:16];
							sh_error_next = dw0_reg[31:24];
							out_act_next = 1'b1;
							in_act_next = 1'b0;
							// Open the outgoing frame with its header dword
							tx_valid_next = 1'b1;
							tx_sof_next = 1'b1;
							tx_eof_next = 1'b0;
							tx_data_next = {24'h000000, `PST_TYPE_DATA};
						end else begin
							// Inbound: shadows stay untouched until data arrives
							hold_status_next = dw0_reg[23:16];
							hold_error_next = dw0_reg[31:24];
							in_wait_next = 1'b1;
							in_act_next = 1'b0;
							out_act_next = 1'b0;
							rd_ptr_next = 12'h000;
						end
					end
				end
				PST_RX_DATA: begin
					// A dword is stored only once the next one shows it is not the CRC
					if (pend_v_reg) begin
						if (wr_ptr_reg == `PST_MAX_DWORDS) begin
							ev[`PST_EV_OVFL] = 1'b1;
						end else begin
							mem_we = 1'b1;
							mem_waddr = wr_ptr_reg[10:0];
							mem_wdata = pend_reg;
							wr_ptr_next = wr_ptr_reg + 12'h001;
						end
					end
					pend_next = rx_data;
					pend_v_next = ~rx_eof;
					if (rx_eof) begin
						rx_state_next = PST_RX_IDLE;
						in_act_next = 1'b1;
						ev[`PST_EV_DATA] = 1'b1;
					end
				end
				PST_RX_SKIP: begin
					if (rx_eof) begin
						rx_state_next = PST_RX_IDLE;
					end
				end
				default: begin
					rx_state_next = PST_RX_IDLE;
				end
			endcase
		end

		// APB: answer in the second access cycle, later for a data write while the link stalls
		if (acc_wait) begin
			pready_next = ~(pwrite && paddr == `PST_OFF_DATA && tx_busy);
			pslverr_next = ~hit;
			case (paddr)
				`PST_OFF_DATA: prdata_next = (in_act_reg && count_reg != 16'h0000) ?
					{16'h0000, half_reg ? mem_q[31:16] : mem_q[15:0]} : 32'h0000_0000;
				`PST_OFF_STATUS: prdata_next = {16'h0000, sh_error_reg, sh_status_reg};
				`PST_OFF_COUNT: prdata_next = {12'h000, in_wait_reg, in_act_reg, out_act_reg,
					half_reg, count_reg};
				`PST_OFF_CTRL: prdata_next = {31'h0000_0000, en_reg};
				`PST_OFF_IRQ_STAT: prdata_next = {{(32-`PST_EV_W){1'b0}}, ist_reg};
				`PST_OFF_IRQ_EN: prdata_next = {{(32-`PST_EV_W){1'b0}}, ien_reg};
				default: prdata_next = 32'h0000_0000;
			endcase
		end

		// Effects land on the edge the master samples pready
		if (acc_done && hit) begin
			if (pwrite) begin
				case (paddr)
					`PST_OFF_DATA: begin
						if (out_act_reg && count_reg != 16'h0000) begin
							count_next = dec_cnt;
							half_next = ~half_reg;
							if (!half_reg) begin
								low_next = pwdata[15:0];
								if (dec_cnt == 16'h0000) begin
									// Odd word count: last word low, high half zero
									tx_valid_next = 1'b1;
									tx_data_next = {16'h0000, pwdata[15:0]};
								end
							end else begin
								tx_valid_next = 1'b1;
								tx_data_next = {pwdata[15:0], low_reg};
							end
							tx_sof_next = 1'b0;
							tx_eof_next = (dec_cnt == 16'h0000);
						end
					end
					`PST_OFF_CTRL: en_next = pwdata[0];
					`PST_OFF_IRQ_EN: ien_next = pwdata[`PST_EV_W-1:0];
					default: begin
					end
				endcase
			end else if (paddr == `PST_OFF_DATA && in_act_reg && count_reg != 16'h0000) begin
				count_next = dec_cnt;
				half_next = ~half_reg;
				if (half_reg) begin
					rd_ptr_next = rd_ptr_reg + 12'h001;
				end
			end
		end

		// Terminal count: ending status goes out in the same edge
		if (count_reg != 16'h0000 && count_next == 16'h0000 && (out_act_reg || in_act_reg)) begin
			sh_status_next = hold_estat_reg;
			out_act_next = 1'b0;
			in_act_next = 1'b0;
			ev[`PST_EV_TERM] = 1'b1;
		end

		// Sticky events; a new event wins over a clear in the same cycle
		ist_next = ist_reg;
		if (acc_done && hit && pwrite && paddr == `PST_OFF_IRQ_CLR) begin
			ist_next = ist_reg & ~pwdata[`PST_EV_W-1:0];
		end
		ist_next = ist_next | ev;
		irq_next = |(ist_next & ien_next);
	end

	// ==========================================================
	// Registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_state_reg <= PST_RX_IDLE;
			idx_reg <= 3'h0;
			dw0_reg <= 32'h0000_0000;
			hold_estat_reg <= 8'h00;
			hold_cnt_reg <= 16'h0000;
			sh_status_reg <= `PST_RST_STATUS;
			sh_error_reg <= 8'h00;
			hold_status_reg <= 8'h00;
			hold_error_reg <= 8'h00;
			count_reg <= 16'h0000;
			out_act_reg <= 1'b0;
			in_wait_reg <= 1'b0;
			in_act_reg <= 1'b0;
			half_reg <= 1'b0;
			low_reg <= 16'h0000;
			wr_ptr_reg <= 12'h000;
			rd_ptr_reg <= 12'h000;
			pend_v_reg <= 1'b0;
			pend_reg <= 32'h0000_0000;
			en_reg <= `PST_RST_CTRL;
			ist_reg <= '0;
			ien_reg <= '0;
			irq_reg <= 1'b0;
			tx_valid_reg <= 1'b0;
			tx_sof_reg <= 1'b0;
			tx_eof_reg <= 1'b0;
			tx_data_reg <= 32'h0000_0000;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
		end else begin
			rx_state_reg <= rx_state_next;
			idx_reg <= idx_next;
			dw0_reg <= dw0_next;
			hold_estat_reg <= hold_estat_next;
			hold_cnt_reg <= hold_cnt_next;
			sh_status_reg <= sh_status_next;
			sh_error_reg <= sh_error_next;
			hold_status_reg <= hold_status_next;
			hold_error_reg <= hold_error_next;
			count_reg <= count_next;
			out_act_reg <= out_act_next;
			in_wait_reg <= in_wait_next;
			in_act_reg <= in_act_next;
			half_reg <= half_next;
			low_reg <= low_next;
			wr_ptr_reg <= wr_ptr_next;
			rd_ptr_reg <= rd_ptr_next;
			pend_v_reg <= pend_v_next;
			pend_reg <= pend_next;
			en_reg <= en_next;
			ist_reg <= ist_next;
			ien_reg <= ien_next;
			irq_reg <= irq_next;
			tx_valid_reg <= tx_valid_next;
			tx_sof_reg <= tx_sof_next;
			tx_eof_reg <= tx_eof_next;
			tx_data_reg <= tx_data_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
			prdata_reg <= prdata_next;
		end
	end

	// ==========================================================
	// Outputs straight from flops
	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign tx_valid = tx_valid_reg;
	assign tx_sof = tx_sof_reg;
	assign tx_eof = tx_eof_reg;
	assign tx_data = tx_data_reg;
	assign irq = irq_reg;
endmodule

// ### inc/pst_params.svh
// Offsets, field positions, reset values and timing counts of the PIO data transport.
`ifndef PST_PARAMS_SVH
`define PST_PARAMS_SVH
// ==========================================================
// Register byte offsets
`define PST_OFF_DATA 12'h000
`define PST_OFF_STATUS 12'h004
`define PST_OFF_COUNT 12'h008
`define PST_OFF_CTRL 12'h00C
`define PST_OFF_IRQ_STAT 12'h010
`define PST_OFF_IRQ_CLR 12'h014
`define PST_OFF_IRQ_EN 12'h018
// ==========================================================
// Frame codes and field positions
`define PST_TYPE_SETUP 8'h5F
`define PST_TYPE_DATA 8'h46
`define PST_DIR_BIT 13
`define PST_MAX_DWORDS 12'h800
// ==========================================================
// Interrupt status bit positions
`define PST_EV_SETUP 0
`define PST_EV_DATA 1
`define PST_EV_TERM 2
`define PST_EV_BADTYPE 3
`define PST_EV_OVFL 4
`define PST_EV_W 5
// ==========================================================
// Reset values
`define PST_RST_STATUS 8'h80
`define PST_RST_CTRL 1'b1
// ==========================================================
// Timing: ending status must land within this time of terminal count
`define PST_ESTAT_MAX_NS 400
`define PST_CLK_NS 25
`define PST_ESTAT_MAX_CYC (`PST_ESTAT_MAX_NS / `PST_CLK_NS)
`endif

// ### inc/pst_pkg.sv
// Types shared by the PIO data transport design files.
package pst_pkg;
	// Receive framing state, one-hot
	typedef enum logic [3:0] {
		PST_RX_IDLE = 4'h1,
		PST_RX_SETUP = 4'h2,
		PST_RX_DATA = 4'h4,
		PST_RX_SKIP = 4'h8
	} pst_rx_state_t;
endpackage
